// ### common/fpa_consts.svh
`ifndef FPA_CONSTS_SVH
`define FPA_CONSTS_SVH

// Clock and time base
`define FPA_CLK_MHZ 50
`define FPA_TICK_US 1000
`define FPA_TICK_CYC (`FPA_CLK_MHZ * `FPA_TICK_US)

// Set-point display and store timeout, seconds
`define FPA_SHOW_S 3
`define FPA_SHOW_TICKS (`FPA_SHOW_S * 1000000 / `FPA_TICK_US)

// Knob rate that forces set-point display with output on
`define FPA_REV_PER_S 2
`define FPA_RATE_TICKS (1000000 / (`FPA_REV_PER_S * `FPA_TICK_US))

// Widths and counts
`define FPA_NUM_CH 4
`define FPA_CNT_W 12
`define FPA_DIV_W 20
`define FPA_STEPS_PER_REV 24

// Adjust indicator colours
`define FPA_LED_OFF 2'h0
`define FPA_LED_GREEN 2'h1
`define FPA_LED_ORANGE 2'h2

`endif

// ### common/fpa_pkg.sv
`include "fpa_consts.svh"

package fpa_pkg;

  typedef enum logic [1:0] {ADJ_NONE, ADJ_COOLER_CHANNEL, ADJ_LASER_CHANNEL} fpa_adj_t;
  typedef enum logic [1:0] {CM_TEMPERATURE, CM_RESISTANCE, CM_COOLER_CURRENT} fpa_cool_mode_t;
  typedef enum logic [1:0] {LM_CURRENT, LM_POWER, LM_WIDEBAND_DRIVE} fpa_las_mode_t;
  typedef enum logic [1:0] {LV_CURRENT, LV_PHOTODIODE_CURRENT, LV_PHOTODIODE_POWER, LV_VOLTAGE} fpa_las_view_t;

  // One-cycle press and knob events from the panel scanner
  typedef struct packed {
    logic adj_cool;
    logic adj_las;
    logic local_sw;
    logic addr_done;
    logic [`FPA_NUM_CH-1:0] out_sw;
    logic cool_mode_sel;
    logic cool_view;
    fpa_cool_mode_t cool_view_sel;
    logic cool_set;
    logic cool_set_held;
    logic las_mode_chg;
    logic knob;
    logic knob_dir;
  } fpa_keys_t;

  typedef struct packed {
    fpa_adj_t adj;
    logic addr_mode;
    logic [`FPA_NUM_CH-1:0] out_on;
    fpa_cool_mode_t [`FPA_NUM_CH-1:0] cool_mode;
    fpa_cool_mode_t cool_meas;
    fpa_cool_mode_t cool_view_led;
    logic cool_shown;
    logic cool_dirty;
    logic [`FPA_CNT_W-1:0] cool_cnt;
    logic las_shown;
    fpa_las_view_t las_view_led;
    logic [`FPA_CNT_W-1:0] las_cnt;
    logic [`FPA_DIV_W-1:0] div_cnt;
    logic tick;
    logic [`FPA_CNT_W-1:0] rate_cnt;
    logic [7:0] step_cnt;
    logic fast;
    logic [1:0] cool_adj_led;
    logic [1:0] las_adj_led;
    logic save_ok;
    logic nv_store;
    logic cool_step;
    logic las_step;
    logic addr_step;
    logic step_dir;
  } fpa_state_t;

endpackage

// ### src/fpa_panel.sv
`timescale 1ns/1ps
`default_nettype none

module fpa_panel
  import fpa_pkg::*;
#(
  parameter int TICK_CYC = `FPA_TICK_CYC,
  parameter int STEPS_PER_REV = `FPA_STEPS_PER_REV
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Panel events
  input wire fpa_keys_t i_keys,
  // Context
  input wire logic i_calib,
  input wire logic [1:0] i_chan_sel,
  input wire logic [`FPA_NUM_CH-1:0] i_cool_present,
  input wire logic [`FPA_NUM_CH-1:0] i_las_present,
  input wire fpa_las_mode_t i_las_mode,
  input wire fpa_las_view_t i_las_view,
  // Mode and indicators
  output logic [1:0] o_adj_mode,
  output logic o_addr_mode,
  output logic o_save_recall_en,
  output logic [1:0] o_cool_adj_led,
  output logic [1:0] o_las_adj_led,
  output logic [`FPA_NUM_CH-1:0] o_out_on,
  output logic [`FPA_NUM_CH-1:0] o_out_led,
  output logic [2*`FPA_NUM_CH-1:0] o_cool_mode,
  output logic [1:0] o_cool_view_led,
  output logic o_cool_set_led,
  output logic [1:0] o_las_view_led,
  output logic o_las_set_led,
  // Set-point and storage strobes
  output logic o_cool_step,
  output logic o_las_step,
  output logic o_addr_step,
  output logic o_step_dir,
  output logic o_nv_store
);

  // Parameters the counters cannot serve
  if (TICK_CYC < 1 || TICK_CYC >= (1 << `FPA_DIV_W))
  begin : g_bad_tick
    $error("TICK_CYC out of range");
  end
  if (STEPS_PER_REV < 1 || STEPS_PER_REV > 255)
  begin : g_bad_steps
    $error("STEPS_PER_REV out of range");
  end

  localparam logic [`FPA_DIV_W-1:0] DIV_LAST = `FPA_DIV_W'(TICK_CYC - 1);
  localparam logic [`FPA_CNT_W-1:0] SHOW_TICKS = `FPA_CNT_W'(`FPA_SHOW_TICKS);
  localparam logic [`FPA_CNT_W-1:0] RATE_TICKS = `FPA_CNT_W'(`FPA_RATE_TICKS);
  localparam logic [7:0] STEPS = 8'(STEPS_PER_REV);

  fpa_state_t s_reg;
  fpa_state_t s_next;

  // Set-point view for the laser: photodiode views pair with power mode
  function automatic fpa_las_view_t las_set_view(input fpa_las_mode_t m, input fpa_las_view_t v);
    fpa_las_view_t r;
    r = LV_CURRENT;
    if (m == LM_POWER)
    begin
      r = (v == LV_PHOTODIODE_CURRENT) ? v : LV_PHOTODIODE_POWER;
    end
    return r;
  endfunction

  // Next state of the whole panel
  always_comb
  begin
    logic cool_adj;
    logic las_adj;
    logic fast_now;
    logic cool_restart;
    logic las_restart;
    s_next = s_reg;
    s_next.nv_store = 1'b0;
    s_next.cool_step = 1'b0;
    s_next.las_step = 1'b0;
    s_next.addr_step = 1'b0;
    s_next.tick = 1'b0;
    cool_restart = 1'b0;
    las_restart = 1'b0;
    cool_adj = (s_reg.adj == ADJ_COOLER_CHANNEL) && !s_reg.addr_mode;
    las_adj = (s_reg.adj == ADJ_LASER_CHANNEL) && !s_reg.addr_mode;

    // Millisecond time base from the system clock
    if (s_reg.div_cnt == DIV_LAST)
    begin
      s_next.div_cnt = '0;
      s_next.tick = 1'b1;
    end
    else
    begin
      s_next.div_cnt = s_reg.div_cnt + 1'b1;
    end

    // Address entry takes over the knob; adjust state is left untouched
    if (i_keys.local_sw && !i_calib)
    begin
      s_next.addr_mode = 1'b1;
    end
    else if (i_keys.addr_done)
    begin
      s_next.addr_mode = 1'b0;
    end

    // Adjust switches; ignored while address entry holds precedence
    if (!s_reg.addr_mode && i_keys.adj_cool && i_cool_present[i_chan_sel])
    begin
      s_next.adj = (s_reg.adj == ADJ_COOLER_CHANNEL) ? ADJ_NONE : ADJ_COOLER_CHANNEL;
    end
    else if (!s_reg.addr_mode && i_keys.adj_las && i_las_present[i_chan_sel])
    begin
      s_next.adj = (s_reg.adj == ADJ_LASER_CHANNEL) ? ADJ_NONE : ADJ_LASER_CHANNEL;
    end

    // Output toggles, then mode changes force the channel off
    s_next.out_on = s_reg.out_on ^ i_keys.out_sw;
    if (cool_adj && i_keys.cool_mode_sel)
    begin
      unique case (s_reg.cool_mode[i_chan_sel])
        CM_TEMPERATURE: s_next.cool_mode[i_chan_sel] = CM_RESISTANCE;
        CM_RESISTANCE: s_next.cool_mode[i_chan_sel] = CM_COOLER_CURRENT;
        default: s_next.cool_mode[i_chan_sel] = CM_TEMPERATURE;
      endcase
      s_next.out_on[i_chan_sel] = 1'b0;
    end
    if (i_keys.las_mode_chg)
    begin
      s_next.out_on[i_chan_sel] = 1'b0;
    end

    // Knob rate over a half-second window (one revolution at 2 rev/s)
    fast_now = s_reg.fast || (i_keys.knob && (s_reg.step_cnt >= STEPS - 8'h01));
    if (s_reg.tick && (s_reg.rate_cnt >= RATE_TICKS - 1'b1))
    begin
      s_next.rate_cnt = '0;
      s_next.fast = s_reg.step_cnt >= STEPS;
      s_next.step_cnt = {7'h00, i_keys.knob};
    end
    else
    begin
      if (s_reg.tick)
      begin
        s_next.rate_cnt = s_reg.rate_cnt + 1'b1;
      end
      if (i_keys.knob && s_reg.step_cnt != 8'hff)
      begin
        s_next.step_cnt = s_reg.step_cnt + 8'h01;
      end
    end

    // Knob routing
    if (i_keys.knob)
    begin
      s_next.step_dir = i_keys.knob_dir;
      if (s_reg.addr_mode)
      begin
        s_next.addr_step = 1'b1;
      end
      else if (cool_adj)
      begin
        s_next.cool_shown = 1'b1;
        s_next.cool_step = 1'b1;
        s_next.cool_dirty = 1'b1;
        cool_restart = 1'b1;
      end
      else if (las_adj)
      begin
        s_next.las_step = 1'b1;
        if (s_reg.las_shown)
        begin
          las_restart = 1'b1;
        end
        else if (i_las_view != LV_VOLTAGE && (!s_reg.out_on[i_chan_sel] || fast_now))
        begin
          s_next.las_shown = 1'b1;
          las_restart = 1'b1;
        end
      end
    end

    // Cooler display switches
    if (i_keys.cool_view)
    begin
      s_next.cool_meas = i_keys.cool_view_sel;
      s_next.cool_shown = 1'b0;
      if (s_next.cool_dirty) // A knob step in the same cycle is stored too
      begin
        s_next.nv_store = 1'b1;
        s_next.cool_dirty = 1'b0;
      end
    end
    else if (i_keys.cool_set || (s_reg.cool_shown && i_keys.cool_set_held))
    begin
      s_next.cool_shown = 1'b1;
      cool_restart = 1'b1;
    end

    // Cooler set-point timeout: store if dirty, back to the measurement in the same cycle
    if (cool_restart)
    begin
      s_next.cool_cnt = SHOW_TICKS;
    end
    else if (s_reg.cool_shown && s_reg.tick)
    begin
      if (s_reg.cool_cnt <= 1)
      begin
        s_next.cool_cnt = '0;
        s_next.cool_shown = 1'b0;
        s_next.nv_store = s_reg.cool_dirty;
        s_next.cool_dirty = 1'b0;
      end
      else
      begin
        s_next.cool_cnt = s_reg.cool_cnt - 1'b1;
      end
    end

    // Laser set-point timeout
    if (las_restart)
    begin
      s_next.las_cnt = SHOW_TICKS;
    end
    else if (s_reg.las_shown && s_reg.tick)
    begin
      if (s_reg.las_cnt <= 1)
      begin
        s_next.las_cnt = '0;
        s_next.las_shown = 1'b0;
      end
      else
      begin
        s_next.las_cnt = s_reg.las_cnt - 1'b1;
      end
    end

    // Indicators registered so every output leaves a flop
    s_next.cool_view_led = s_next.cool_shown ? s_next.cool_mode[i_chan_sel] : s_next.cool_meas;
    s_next.las_view_led = s_next.las_shown ? las_set_view(i_las_mode, i_las_view) : i_las_view;
    s_next.save_ok = (s_next.adj == ADJ_NONE);
    s_next.cool_adj_led = !i_cool_present[i_chan_sel] ? `FPA_LED_OFF :
      (s_next.adj == ADJ_COOLER_CHANNEL) ? `FPA_LED_ORANGE : `FPA_LED_GREEN;
    s_next.las_adj_led = !i_las_present[i_chan_sel] ? `FPA_LED_OFF :
      (s_next.adj == ADJ_LASER_CHANNEL) ? `FPA_LED_ORANGE : `FPA_LED_GREEN;
  end

  // Panel state register; outputs off at power-up
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      s_reg <= '0;
      s_reg.save_ok <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign o_adj_mode = s_reg.adj;
  assign o_addr_mode = s_reg.addr_mode;
  assign o_save_recall_en = s_reg.save_ok;
  assign o_cool_adj_led = s_reg.cool_adj_led;
  assign o_las_adj_led = s_reg.las_adj_led;
  assign o_out_on = s_reg.out_on;
  assign o_out_led = s_reg.out_on;
  assign o_cool_mode = s_reg.cool_mode;
  assign o_cool_view_led = s_reg.cool_view_led;
  assign o_cool_set_led = s_reg.cool_shown;
  assign o_las_view_led = s_reg.las_view_led;
  assign o_las_set_led = s_reg.las_shown;
  assign o_cool_step = s_reg.cool_step;
  assign o_las_step = s_reg.las_step;
  assign o_addr_step = s_reg.addr_step;
  assign o_step_dir = s_reg.step_dir;
  assign o_nv_store = s_reg.nv_store;

endmodule

`default_nettype wire

// ### verif/fpa_panel_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpa_consts.svh"

module fpa_panel_properties
  import fpa_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Watched inputs
  input wire fpa_keys_t i_keys,
  input wire logic i_calib,
  input wire logic [1:0] i_chan_sel,
  // Watched outputs
  input wire logic [1:0] o_adj_mode,
  input wire logic o_addr_mode,
  input wire logic o_save_recall_en,
  input wire logic [`FPA_NUM_CH-1:0] o_out_on,
  input wire logic [`FPA_NUM_CH-1:0] o_out_led,
  input wire logic [2*`FPA_NUM_CH-1:0] o_cool_mode,
  input wire logic [1:0] o_cool_view_led,
  input wire logic o_cool_set_led,
  input wire logic o_cool_step
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // Competing presses make the outcome depend on priority, so keep them out
  logic quiet;
  logic cool0;
  assign quiet = !(i_keys.adj_cool || i_keys.adj_las || i_keys.local_sw || i_keys.cool_view || i_keys.cool_set);
  assign cool0 = o_adj_mode == 2'h1 && !o_addr_mode && i_chan_sel == 2'h0;

  // Knob answer: step strobe with set point shown for the selected mode
  sequence s_set_step;
    o_cool_step && o_cool_set_led;
  endsequence
  sequence s_mode_view;
    o_cool_view_led == o_cool_mode[1:0];
  endsequence

  a_one_adjust: assert property (o_adj_mode != 2'h3) else $error("two adjust modes");
  a_save_gate: assert property (1'b1 |-> ##1 (o_save_recall_en == (o_adj_mode == 2'h0)))
    else $error("save enable wrong");
  a_addr_enter: assert property (i_keys.local_sw && !i_calib |=> o_addr_mode) else $error("no address mode");
  a_addr_keeps: assert property (o_addr_mode |=> $stable(o_adj_mode)) else $error("adjust lost");
  a_cool_knob: assert property (i_keys.knob && cool0 && quiet && !i_keys.cool_mode_sel |=> s_set_step ##0 s_mode_view)
    else $error("knob set view");
  a_out_toggle: assert property (i_keys.out_sw[0] && !i_keys.las_mode_chg && !(i_keys.cool_mode_sel && cool0)
    |=> o_out_on[0] != $past(o_out_on[0])) else $error("no toggle");
  a_led_match: assert property (o_out_led == o_out_on) else $error("output led differs");
  a_mode_cycle: assert property (i_keys.cool_mode_sel && cool0 && quiet |=> !o_out_on[0]
    && o_cool_mode[1:0] == (($past(o_cool_mode[1:0]) == 2'h2) ? 2'h0 : $past(o_cool_mode[1:0]) + 2'h1))
    else $error("mode cycle");
endmodule

bind fpa_panel fpa_panel_properties i_props (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_keys(i_keys), .i_calib(i_calib), .i_chan_sel(i_chan_sel),
  .o_adj_mode(o_adj_mode), .o_addr_mode(o_addr_mode), .o_save_recall_en(o_save_recall_en),
  .o_out_on(o_out_on), .o_out_led(o_out_led), .o_cool_mode(o_cool_mode),
  .o_cool_view_led(o_cool_view_led), .o_cool_set_led(o_cool_set_led), .o_cool_step(o_cool_step)
);
`default_nettype wire

// ### verif/fpa_operator.sv
`timescale 1ns/1ps
`default_nettype none

module fpa_operator
  import fpa_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Panel events
  output var fpa_keys_t o_keys
);
  initial o_keys = '0;

  // One press lasts one cycle; a held set switch is never claimed
  // The bench picks the cooler mode before knob work on its set point
  task automatic press(input fpa_keys_t k);
    @(posedge i_clk);
    o_keys <= k;
    @(posedge i_clk);
    o_keys <= '0;
  endtask
endmodule
`default_nettype wire

// ### verif/fpa_panel_tb.sv
`timescale 1ns/1ps
`default_nettype none

module fpa_panel_tb
  import fpa_pkg::*;
;
  localparam int TICK = 2;
  localparam int LIMIT = 20000;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_calib = 1'b0;
  logic [1:0] chan = 2'h0;
  logic [3:0] present = 4'hf;
  fpa_las_mode_t las_mode = LM_CURRENT;
  fpa_las_view_t las_view = LV_CURRENT;
  fpa_keys_t keys;
  fpa_keys_t k;
  logic [1:0] adj, cled, lled, cview, lview;
  logic addr, save, cset, lset, cstep, lstep, astep, dir, nv;
  logic [3:0] on, led, eo;
  logic [7:0] cmode;
  logic [3:0] exp_q[$];
  logic [31:0] rnd = 32'hd7338774;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int n;

  always #10 i_clk = ~i_clk;

  fpa_operator i_op (.i_clk(i_clk), .o_keys(keys));

  // Short tick keeps the three-second timeout near 6000 cycles
  fpa_panel #(.TICK_CYC(TICK), .STEPS_PER_REV(4)) i_dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_keys(keys), .i_calib(i_calib), .i_chan_sel(chan),
    .i_cool_present(present), .i_las_present(present), .i_las_mode(las_mode), .i_las_view(las_view),
    .o_adj_mode(adj), .o_addr_mode(addr), .o_save_recall_en(save), .o_cool_adj_led(cled),
    .o_las_adj_led(lled), .o_out_on(on), .o_out_led(led), .o_cool_mode(cmode), .o_cool_view_led(cview),
    .o_cool_set_led(cset), .o_las_view_led(lview), .o_las_set_led(lset), .o_cool_step(cstep),
    .o_las_step(lstep), .o_addr_step(astep), .o_step_dir(dir), .o_nv_store(nv)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Press k, then look once the answer has landed
  task automatic hit;
    i_op.press(k);
    @(negedge i_clk);
  endtask

  // Each strobe takes the oldest note
  always @(negedge i_clk)
  begin
    if (!i_sys_rst && (cstep || lstep || astep || nv))
    begin
      if (exp_q.size() == 0)
        check({nv, astep, lstep, cstep}, 8'h0, "unexpected strobe");
      else
        check({nv, astep, lstep, cstep}, exp_q.pop_front(), "strobe");
    end
  end

  // Hang guard
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      errors++;
      $display("mismatch %0t timeout", $time);
      summarize();
    end
  end

  initial
  begin
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(negedge i_clk);
    check({adj, on}, 8'h0, "reset");
    k = '0; k.adj_las = 1'b1; hit();
    check({adj, lled, cled}, {2'h2, 2'h2, 2'h1}, "laser adjust");
    k = '0; k.adj_cool = 1'b1; hit();
    check({adj, lled, cled, save}, {2'h1, 2'h1, 2'h2, 1'b0}, "cooler adjust");
    $display("test adjust done");
    @(posedge i_clk);
    i_calib <= 1'b1;
    k = '0; k.local_sw = 1'b1; hit();
    check(addr, 8'h00, "calibration blocks");
    @(posedge i_clk);
    i_calib <= 1'b0;
    hit();
    check({addr, adj}, {1'b1, 2'h1}, "address entry");
    k = '0; k.adj_las = 1'b1; hit();
    exp_q.push_back(4'h4);
    k = '0; k.knob = 1'b1; hit();
    check({addr, adj}, {1'b1, 2'h1}, "address overrides");
    k = '0; k.addr_done = 1'b1; hit();
    check({addr, adj}, {1'b0, 2'h1}, "restore");
    $display("test address done");
    eo = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      k = '0; k.out_sw[i] = 1'b1; hit();
      eo[i] = 1'b1;
      check({on, led}, {eo, eo}, "output on");
    end
    rnd = lfsr(rnd);
    k = '0; k.out_sw[{rnd[1], 1'b1}] = 1'b1; hit();
    eo[{rnd[1], 1'b1}] = 1'b0;
    check({on, led}, {eo, eo}, "output off");
    for (int i = 1; i < 4; i++)
    begin
      k = '0; k.cool_mode_sel = 1'b1; hit();
      eo[0] = 1'b0;
      check({cmode[1:0], on}, {2'(i % 3), eo}, "mode select");
    end
    $display("test outputs done");
    k = '0; k.cool_view = 1'b1; k.cool_view_sel = CM_RESISTANCE; hit();
    check({cset, cview}, {1'b0, 2'h1}, "measure view");
    rnd = lfsr(rnd);
    exp_q.push_back(4'h1);
    k = '0; k.knob = 1'b1; k.knob_dir = rnd[0]; hit();
    check({cset, cview, dir}, {1'b1, 2'h0, rnd[0]}, "knob set view");
    exp_q.push_back(4'h8);
    n = 0;
    while (cset === 1'b1 && n < 7000)
    begin
      @(negedge i_clk);
      n++;
    end
    check({n >= 2999 * TICK, n <= 3002 * TICK, cview}, {2'b11, 2'h1}, "timeout store");
    k = '0; k.cool_set = 1'b1; hit();
    check({cset, cview}, {1'b1, 2'h0}, "set press");
    exp_q.push_back(4'h1);
    exp_q.push_back(4'h8);
    k = '0; k.knob = 1'b1; hit();
    k = '0; k.cool_view = 1'b1; k.cool_view_sel = CM_COOLER_CURRENT; hit();
    check({cset, cview}, {1'b0, 2'h2}, "view press stores");
    $display("test cooler set point done");
    k = '0; k.adj_cool = 1'b1; hit();
    check({adj, save}, {2'h0, 1'b1}, "save allowed");
    // Absent module: adjust press refused, indicators dark
    @(posedge i_clk);
    present <= 4'he;
    k = '0; k.adj_cool = 1'b1; hit();
    check({adj, cled, lled}, 6'h00, "absent module");
    @(posedge i_clk);
    present <= 4'hf;
    las_view <= LV_PHOTODIODE_CURRENT;
    k = '0; k.adj_las = 1'b1; hit();
    exp_q.push_back(4'h2);
    k = '0; k.knob = 1'b1; hit();
    check({lset, lview}, {1'b1, 2'h0}, "laser set view");
    n = 0;
    while (lset === 1'b1 && n < 7000)
    begin
      @(negedge i_clk);
      n++;
    end
    check({n >= 2999 * TICK, n <= 3002 * TICK, lview}, {2'b11, 2'h1}, "laser timeout");
    // Output on: one detent keeps the measurement, a burst shows the set point
    @(posedge i_clk);
    las_mode <= LM_POWER;
    las_view <= LV_CURRENT;
    k = '0; k.out_sw[0] = 1'b1; hit();
    exp_q.push_back(4'h2);
    k = '0; k.knob = 1'b1; hit();
    check({lset, lview, on[0]}, {1'b0, 2'h0, 1'b1}, "slow knob keeps view");
    for (int i = 0; i < 7; i++)
    begin
      exp_q.push_back(4'h2);
      hit();
    end
    check({lset, lview}, {1'b1, 2'h2}, "fast knob set view");
    k = '0; k.las_mode_chg = 1'b1; hit();
    check({lset, on[0]}, 2'b10, "laser mode forces off");
    repeat (2) @(negedge i_clk);
    check(8'(exp_q.size()), 8'h0, "strobes seen");
    $display("test laser done");
    summarize();
  end
endmodule
`default_nettype wire
